// *** src/frame_fifo_map.vh ***
// register offsets, field layout, queue depths and reset values of the
// two-channel frame queue front end; definitions only
`ifndef FRAME_FIFO_MAP_VH
`define FRAME_FIFO_MAP_VH

// ****************************************
// address map
// ****************************************
`define CH_SEL_BIT 7
`define OFF_W 7
`define REG_DATA 7'h00
`define REG_LEN 7'h04
`define REG_TRIG 7'h08
`define REG_LEVEL 7'h0C
`define REG_FRAMES 7'h10

// ****************************************
// field layout
// ****************************************
`define TRANSMIT_THRESHOLD_MSB 27
`define TRANSMIT_THRESHOLD_LSB 16
`define TRANSMIT_THRESHOLD_W 12
`define RECEIVE_THRESHOLD_MSB 12
`define RECEIVE_THRESHOLD_LSB 0
`define RECEIVE_THRESHOLD_W 13
`define TXLVL_W 13
`define RXLVL_W 14
`define TXFRM_W 9
`define RXFRM_W 10
`define WORD_BYTES_W 3

// ****************************************
// queue geometry
// ****************************************
`define TXQ_DEPTH 1024
`define TXQ_AW 10
`define TXLQ_DEPTH 256
`define TXLQ_AW 8
`define RXQ_DEPTH 2048
`define RXQ_AW 11
`define RXLQ_DEPTH 512
`define RXLQ_AW 9
`define RXQ_ROOM_LIM 12'h7FF
`define RXLQ_ROOM_LIM 10'h1FF

// ****************************************
// reset values
// ****************************************
`define TRANSMIT_THRESHOLD_RST 12'h000
`define RECEIVE_THRESHOLD_RST 13'h0000
`define RXLVL_RST 14'h0000
`define FRAME_ACC_RST 32'h00000000

`endif

// *** src/sync_queue.v ***
// flip-flop first-in first-out queue with registered pop data
// assumes one clock, synchronous reset and a clock enable from the parent

module sync_queue #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and control
    input wire clk,
    input wire srst,
    input wire ce,
    // fill side
    input wire push,
    input wire [WIDTH-1:0] pushData,
    // drain side
    input wire pop,
    output reg [WIDTH-1:0] popData,
    // occupancy
    output reg [AW:0] count,
    output wire full,
    output wire empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    wire pushOk;
    wire popOk;

    // depth is a power of two, so the top count bit alone marks full
    assign full = count[AW];
    assign empty = (count == {(AW+1){1'b0}});
    assign pushOk = push && !full;
    assign popOk = pop && !empty;

    // storage carries no reset; only pointers define content
    always @(posedge clk) begin
        if (ce && pushOk) begin
            mem[wrPtr] <= pushData;
        end
    end

    // pointers, occupancy and the registered head word
    always @(posedge clk) begin
        if (srst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            popData <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (pushOk) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (popOk) begin
                popData <= mem[rdPtr];
                rdPtr <= rdPtr + 1'b1;
            end
            case ({pushOk, popOk})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule // sync_queue

// *** src/dual_channel_frame_fifo_regs.v ***
// host register front end of two serial channels: data, frame length,
// threshold, fill level and queued frame registers per channel
// assumes one clock, host accesses of one cycle, a framing engine that
// pops transmit words and pushes receive words with their byte counts
//
// What this block does
// - each host word write to a channel's data location joins that channel's transmit queue while it is not full.
// - each host word read of the data location returns and removes the next receive word.
// - each receive length entry equals all bytes pushed into the receive queue for the frame.
// - a receive length entry is queued only when its frame has ended.
// - the transmit threshold is a 12-bit byte count in bits 27:16 of the threshold register.
// - the transmit event is raised while the transmit fill level is below that threshold.
// - the receive threshold is a 13-bit byte count in bits 12:0 of the threshold register.
// - the receive event is raised while the receive fill level is above that threshold.
// - the fill level register shows the transmit byte level, 13 bits, in its upper half.
// - the fill level register shows the receive byte level, 14 bits, in its lower half.
// - the threshold register is read-write at 0x08 and 0x88.
// - the fill level register is read-only at 0x0C and 0x8C.
// - the queued frame register is read-only at 0x10 and 0x90.
// - the transmit queued frame field is 9 bits in the upper half, from 0 to 256.
// - the receive queued frame field is 10 bits in the lower half, from 0 to 512.
`include "frame_fifo_map.vh"

module dual_channel_frame_fifo_regs (
    // clock, reset, enable
    input wire clk,
    input wire srst,
    input wire ce,
    // host register port
    input wire [7:0] hostAddr,
    input wire hostWrEn,
    input wire [31:0] hostWrData,
    input wire hostRdEn,
    output reg [31:0] hostRdData,
    output reg hostRdValid,
    // transmit engine side, channel n in slice n
    input wire [1:0] txWordPop,
    output wire [63:0] txWord,
    output wire [1:0] txWordValid,
    output wire [1:0] txWordAvail,
    input wire [1:0] txLenPop,
    output wire [63:0] txLen,
    output wire [1:0] txLenValid,
    output wire [1:0] txLenAvail,
    // receive engine side
    input wire [1:0] rxWordPush,
    input wire [63:0] rxWordIn,
    input wire [5:0] rxWordBytes,
    input wire [1:0] rxFrameEnd,
    output wire [1:0] rxRoom,
    // threshold events
    output wire [1:0] transmitThresholdEvent,
    output wire [1:0] receiveThresholdEvent
);
    // ****************************************
    // shared decode and read pipeline
    // ****************************************
    reg rdPend;
    reg [7:0] rdAddrQ;
    wire [63:0] chRd;

    // one decode used by every register strobe of both channels
    function isReg;
        input [7:0] a;
        input ch;
        input [`OFF_W-1:0] off;
        begin
            isReg = (a[`CH_SEL_BIT] == ch) && (a[`OFF_W-1:0] == off);
        end
    endfunction

    // reads answer two cycles after the strobe so popped words can settle
    always @(posedge clk) begin
        if (srst) begin
            rdPend <= 1'b0;
            rdAddrQ <= 8'h00;
            hostRdValid <= 1'b0;
            hostRdData <= 32'h00000000;
        end else if (ce) begin
            rdPend <= hostRdEn;
            rdAddrQ <= hostAddr;
            hostRdValid <= rdPend;
            // data holds between answers so a slow host can still pick it up
            if (rdPend) begin
                hostRdData <= rdAddrQ[`CH_SEL_BIT] ? chRd[63:32] : chRd[31:0];
            end
        end
    end

    // ****************************************
    // per channel queues and registers
    // ****************************************
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : chan
            localparam [0:0] CH = (c == 1) ? 1'b1 : 1'b0;
            wire txDataWr;
            wire txLenWr;
            wire trigWr;
            wire rxDataRd;
            wire rxLenRd;
            wire [`TXQ_AW:0] txCount;
            wire [`TXLQ_AW:0] txLenCount;
            wire [`RXQ_AW:0] rxCount;
            wire [`RXLQ_AW:0] rxLenCount;
            wire txEmpty;
            wire txLenEmpty;
            wire rxFull;
            wire rxEmpty;
            wire rxLenEmpty;
            wire [34:0] rxHead;
            wire [31:0] rxLenHead;
            wire rxPushOk;
            wire [2:0] pushBytes;
            wire [31:0] frameSum;
            wire [`TXLVL_W-1:0] txLevel;
            reg [`TRANSMIT_THRESHOLD_W-1:0] txThr;
            reg [`RECEIVE_THRESHOLD_W-1:0] rxThr;
            reg [`RXLVL_W-1:0] rxLevel;
            reg [31:0] frameAcc;
            reg rxLenPush;
            reg [31:0] rxLenData;
            reg rxDataPopped;
            reg rxLenPopped;
            reg wordValid;
            reg lenValid;
            reg wordAvail;
            reg lenAvail;
            reg room;
            reg txEvt;
            reg rxEvt;
            reg [31:0] rdVal;

            // host strobes
            assign txDataWr = hostWrEn && isReg(hostAddr, CH, `REG_DATA);
            assign txLenWr = hostWrEn && isReg(hostAddr, CH, `REG_LEN);
            assign trigWr = hostWrEn && isReg(hostAddr, CH, `REG_TRIG);
            assign rxDataRd = hostRdEn && isReg(hostAddr, CH, `REG_DATA);
            assign rxLenRd = hostRdEn && isReg(hostAddr, CH, `REG_LEN);

            // transmit data, 1024 words of 4 bytes
            sync_queue #(.WIDTH(32), .DEPTH(`TXQ_DEPTH), .AW(`TXQ_AW)) txQ (
                .clk(clk), .srst(srst), .ce(ce),
                .push(txDataWr), .pushData(hostWrData),
                .pop(txWordPop[c]), .popData(txWord[c*32 +: 32]),
                .count(txCount), .full(), .empty(txEmpty)
            );

            // transmit frame lengths, written ahead of their data by the host
            sync_queue #(.WIDTH(32), .DEPTH(`TXLQ_DEPTH), .AW(`TXLQ_AW)) txLenQ (
                .clk(clk), .srst(srst), .ce(ce),
                .push(txLenWr), .pushData(hostWrData),
                .pop(txLenPop[c]), .popData(txLen[c*32 +: 32]),
                .count(txLenCount), .full(), .empty(txLenEmpty)
            );

            // receive data, 2048 entries of one word plus its byte count
            sync_queue #(.WIDTH(35), .DEPTH(`RXQ_DEPTH), .AW(`RXQ_AW)) rxQ (
                .clk(clk), .srst(srst), .ce(ce),
                .push(rxWordPush[c]),
                .pushData({rxWordBytes[c*3 +: 3], rxWordIn[c*32 +: 32]}),
                .pop(rxDataRd), .popData(rxHead),
                .count(rxCount), .full(rxFull), .empty(rxEmpty)
            );

            // receive frame lengths
            sync_queue #(.WIDTH(32), .DEPTH(`RXLQ_DEPTH), .AW(`RXLQ_AW)) rxLenQ (
                .clk(clk), .srst(srst), .ce(ce),
                .push(rxLenPush), .pushData(rxLenData),
                .pop(rxLenRd), .popData(rxLenHead),
                .count(rxLenCount), .full(), .empty(rxLenEmpty)
            );

            // only bytes that really entered the queue are counted
            assign rxPushOk = rxWordPush[c] && !rxFull;
            assign pushBytes = rxPushOk ? rxWordBytes[c*3 +: 3] : 3'h0;
            assign frameSum = frameAcc + {29'h00000000, pushBytes};
            assign txLevel = {txCount[`TXQ_AW:0], 2'h0};

            // thresholds, frame accounting, levels and engine flags
            always @(posedge clk) begin
                if (srst) begin
                    txThr <= `TRANSMIT_THRESHOLD_RST;
                    rxThr <= `RECEIVE_THRESHOLD_RST;
                    rxLevel <= `RXLVL_RST;
                    frameAcc <= `FRAME_ACC_RST;
                    rxLenPush <= 1'b0;
                    rxLenData <= `FRAME_ACC_RST;
                    rxDataPopped <= 1'b0;
                    rxLenPopped <= 1'b0;
                    wordValid <= 1'b0;
                    lenValid <= 1'b0;
                    wordAvail <= 1'b0;
                    lenAvail <= 1'b0;
                    room <= 1'b0;
                    txEvt <= 1'b0;
                    rxEvt <= 1'b0;
                end else if (ce) begin
                    if (trigWr) begin
                        txThr <= hostWrData[`TRANSMIT_THRESHOLD_MSB:`TRANSMIT_THRESHOLD_LSB];
                        rxThr <= hostWrData[`RECEIVE_THRESHOLD_MSB:`RECEIVE_THRESHOLD_LSB];
                    end
                    // the length entry leaves only with the frame's end
                    rxLenPush <= rxFrameEnd[c];
                    rxLenData <= frameSum;
                    frameAcc <= rxFrameEnd[c] ? `FRAME_ACC_RST : frameSum;
                    rxDataPopped <= rxDataRd && !rxEmpty;
                    rxLenPopped <= rxLenRd && !rxLenEmpty;
                    // popped bytes are known one cycle late, from the head word
                    rxLevel <= rxLevel + {11'h000, pushBytes}
                        - (rxDataPopped ? {11'h000, rxHead[34:32]} : `RXLVL_RST);
                    wordValid <= txWordPop[c] && !txEmpty;
                    lenValid <= txLenPop[c] && !txLenEmpty;
                    wordAvail <= !txEmpty;
                    lenAvail <= !txLenEmpty;
                    // two free entries kept so a stale flag cannot overflow
                    room <= (rxCount < `RXQ_ROOM_LIM)
                        && (rxLenCount < `RXLQ_ROOM_LIM);
                    txEvt <= (txLevel < {1'b0, txThr});
                    rxEvt <= (rxLevel > {1'b0, rxThr});
                end
            end

            // read value of this channel, picked by the delayed offset
            always @* begin
                rdVal = 32'h00000000;
                case (rdAddrQ[`OFF_W-1:0])
                    `REG_DATA: rdVal = rxDataPopped ? rxHead[31:0] : 32'h00000000;
                    `REG_LEN: rdVal = rxLenPopped ? rxLenHead : 32'h00000000;
                    `REG_TRIG: rdVal = {4'h0, txThr, 3'h0, rxThr};
                    `REG_LEVEL: rdVal = {3'h0, txLevel, 2'h0, rxLevel};
                    `REG_FRAMES: rdVal = {7'h00, txLenCount, 6'h00, rxLenCount};
                    default: rdVal = 32'h00000000;
                endcase
            end

            assign chRd[c*32 +: 32] = rdVal;
            assign txWordValid[c] = wordValid;
            assign txLenValid[c] = lenValid;
            assign txWordAvail[c] = wordAvail;
            assign txLenAvail[c] = lenAvail;
            assign rxRoom[c] = room;
            assign transmitThresholdEvent[c] = txEvt;
            assign receiveThresholdEvent[c] = rxEvt;
        end
    endgenerate
endmodule // dual_channel_frame_fifo_regs

// *** verif/frame_fifo_asserts.sv ***
// checker for the read pipeline, transmit pops and reset state
// assumes binding to the top module; ce drops only while no read is in flight
module frame_fifo_asserts (
    // clock and reset
    input wire clk,
    input wire srst,
    input wire ce,
    // host port
    input wire hostRdEn,
    input wire [31:0] hostRdData,
    input wire hostRdValid,
    // transmit engine side
    input wire [1:0] txWordPop,
    input wire [63:0] txWord,
    input wire [1:0] txWordValid,
    input wire [1:0] txLenPop,
    input wire [63:0] txLen,
    input wire [1:0] txLenValid,
    input wire [1:0] transmitThresholdEvent
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_RD_ANSWER: assert property (hostRdEn && ce ##1 ce |-> ##1 hostRdValid)
        else $error("read not answered");
    AST_RD_CAUSE: assert property (hostRdValid |-> $past(hostRdEn, 2))
        else $error("read answer without request");
    AST_RD_PULSE: assert property (hostRdEn ##1 !hostRdEn |-> ##1 hostRdValid ##1 !hostRdValid)
        else $error("read answer longer than one cycle");
    AST_RD_HOLD: assert property (!hostRdValid |-> $stable(hostRdData))
        else $error("read data moved without answer");
    AST_TX_CAUSE: assert property ((txWordValid & ~$past(txWordPop)) == 2'b00)
        else $error("word handed out without pop");
    AST_TX_HOLD: assert property (txWordValid == 2'b00 |-> $stable(txWord))
        else $error("word moved without pop");
    AST_LEN_CAUSE: assert property ((txLenValid & ~$past(txLenPop)) == 2'b00)
        else $error("length handed out without pop");
    AST_LEN_HOLD: assert property (txLenValid == 2'b00 |-> $stable(txLen))
        else $error("length moved without pop");
    AST_RST_IDLE: assert property ($past(srst) |-> !hostRdValid && transmitThresholdEvent == 2'b00)
        else $error("outputs active after reset");
    // main scenarios reached
    cover property (hostRdValid);
    cover property (txWordValid[1]);
    cover property (txLenValid[0]);
endmodule // frame_fifo_asserts

// *** verif/frame_engine.sv ***
// framing engine model: pops transmit words and lengths, pushes receive words
// assumes the bench calls its tasks; drives at the falling edge
module frame_engine (
    // clock
    input wire clk,
    // transmit side
    output logic [1:0] txWordPop,
    input wire [63:0] txWord,
    input wire [1:0] txWordValid,
    output logic [1:0] txLenPop,
    input wire [63:0] txLen,
    input wire [1:0] txLenValid,
    // receive side
    output logic [1:0] rxWordPush,
    output logic [63:0] rxWordIn,
    output logic [5:0] rxWordBytes,
    output logic [1:0] rxFrameEnd,
    input wire [1:0] rxRoom
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gotQ[$];
    // ****************************************
    // behaviour
    // ****************************************
    initial begin
        txWordPop = 2'h0;
        txLenPop = 2'h0;
        rxWordPush = 2'h0;
        rxWordIn = 64'h0;
        rxWordBytes = 6'h0;
        rxFrameEnd = 2'h0;
    end
    // everything handed out is kept in arrival order
    always @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (txLenValid[c]) gotQ.push_back(txLen[32*c+:32]);
            if (txWordValid[c]) gotQ.push_back(txWord[32*c+:32]);
        end
    end
    task automatic pop(input int c, input bit len);
        @(negedge clk);
        if (len) txLenPop[c] = 1'b1;
        else txWordPop[c] = 1'b1;
        @(negedge clk);
        txLenPop = 2'h0;
        txWordPop = 2'h0;
    endtask
    task automatic push(input int c, input [31:0] w, input [2:0] b, input bit last);
        int n;
        n = 0;
        // push waits up to 100 cycles for room, as a real engine would stall
        while (rxRoom[c] !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        rxWordIn[32*c+:32] = w;
        rxWordBytes[3*c+:3] = b;
        rxWordPush[c] = 1'b1;
        rxFrameEnd[c] = last;
        @(negedge clk);
        rxWordPush = 2'h0;
        rxFrameEnd = 2'h0;
        rxWordIn = ~rxWordIn; // released bus never shows the stale word
    endtask
endmodule // frame_engine

// *** verif/testbench.sv ***
// self-checking bench of the two-channel frame queue front end
// assumes the engine model beside it and the checker bound below
`include "frame_fifo_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] hostAddr = 8'h00;
    logic hostWrEn = 1'b0;
    logic [31:0] hostWrData = 32'h0;
    logic hostRdEn = 1'b0;
    logic ce = 1'b1;
    wire [31:0] hostRdData;
    wire hostRdValid;
    wire [1:0] txWordPop, txWordValid, txWordAvail, txLenPop, txLenValid, txLenAvail;
    wire [63:0] txWord, txLen, rxWordIn;
    wire [1:0] rxWordPush, rxFrameEnd, rxRoom, txEv, rxEv;
    wire [5:0] rxWordBytes;
    int error_cnt = 0, check_count = 0, seed = 31, cyc = 0, c, i, nw, nr, s, lb;
    logic [31:0] v, w[8], r[8];
    logic [7:0] b;
    always #2.5 clk = ~clk;
    dual_channel_frame_fifo_regs uut (.clk(clk), .srst(srst), .ce(ce),
        .hostAddr(hostAddr), .hostWrEn(hostWrEn), .hostWrData(hostWrData),
        .hostRdEn(hostRdEn), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .txWordPop(txWordPop), .txWord(txWord), .txWordValid(txWordValid),
        .txWordAvail(txWordAvail), .txLenPop(txLenPop), .txLen(txLen),
        .txLenValid(txLenValid), .txLenAvail(txLenAvail), .rxWordPush(rxWordPush),
        .rxWordIn(rxWordIn), .rxWordBytes(rxWordBytes), .rxFrameEnd(rxFrameEnd),
        .rxRoom(rxRoom), .transmitThresholdEvent(txEv), .receiveThresholdEvent(rxEv));
    frame_engine eng (.clk(clk), .txWordPop(txWordPop), .txWord(txWord),
        .txWordValid(txWordValid), .txLenPop(txLenPop), .txLen(txLen),
        .txLenValid(txLenValid), .rxWordPush(rxWordPush), .rxWordIn(rxWordIn),
        .rxWordBytes(rxWordBytes), .rxFrameEnd(rxFrameEnd), .rxRoom(rxRoom));
    // ****************************************
    // tasks
    // ****************************************
    function automatic [31:0] trigv(input [31:0] d);
        return d & 32'h0FFF1FFF; // only the two threshold fields persist
    endfunction
    task automatic chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        @(negedge clk);
        hostAddr = a;
        hostWrData = d;
        hostWrEn = 1'b1;
        @(negedge clk);
        hostWrEn = 1'b0;
    endtask
    task automatic rdc(input [7:0] a, input [31:0] exp);
        logic [31:0] d;
        d = 'x;
        @(negedge clk);
        hostAddr = a;
        hostRdEn = 1'b1;
        @(negedge clk);
        hostRdEn = 1'b0;
        for (int n = 0; n < 3; n++) begin
            @(posedge clk);
            #1;
            if (hostRdValid === 1'b1) d = hostRdData;
        end
        chk(d, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, far beyond the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        for (c = 0; c < 2; c++) begin
            b = {c[0], 7'h00};
            rdc(b | `REG_TRIG, 32'h0);
            rdc(b | `REG_LEVEL, 32'h0);
            rdc(b | `REG_FRAMES, 32'h0);
            rdc(b | 8'h14, 32'h0);
            chk({31'h0, rxRoom[c]}, 32'h1);
            v = $random(seed);
            wr(b | `REG_TRIG, v);
            rdc(b | `REG_TRIG, trigv(v));
            wr(b | `REG_LEVEL, v);
            wr(b | `REG_FRAMES, v);
            rdc(b | `REG_LEVEL, 32'h0);
            rdc(b | `REG_FRAMES, 32'h0);
            // transmit frame: length first, then words
            nw = ($random(seed) & 7) + 1;
            wr(b | `REG_LEN, nw * 4);
            for (i = 0; i < nw; i++) begin
                w[i] = $random(seed);
                wr(b | `REG_DATA, w[i]);
            end
            rdc(b | `REG_LEVEL, (nw * 4) << 16);
            rdc(b | `REG_FRAMES, 32'h00010000);
            chk({30'h0, txLenAvail[c], txWordAvail[c]}, 32'h3);
            nr = ($random(seed) & 3) + 2;
            lb = ($random(seed) & 3) + 1;
            s = (nr - 1) * 4 + lb;
            // threshold equal to the level: strict compare keeps event low
            v = ((nw * 4) << 16) | (s - 1);
            wr(b | `REG_TRIG, v);
            repeat (3) @(negedge clk);
            chk({31'h0, txEv[c]}, 32'h0);
            chk({31'h0, rxEv[c]}, 32'h0);
            eng.pop(c, 1'b1);
            eng.pop(c, 1'b0);
            repeat (3) @(negedge clk);
            chk({31'h0, txEv[c]}, 32'h1);
            for (i = 1; i < nw; i++) eng.pop(c, 1'b0);
            repeat (2) @(negedge clk);
            chk({30'h0, txLenAvail[c], txWordAvail[c]}, 32'h0);
            chk(eng.gotQ.pop_front(), nw * 4);
            for (i = 0; i < nw; i++) chk(eng.gotQ.pop_front(), w[i]);
            rdc(b | `REG_LEVEL, 32'h0);
            // corner: one word past the depth is refused, level tops out at 4096
            for (i = 0; i <= 1024; i++) wr(b | `REG_DATA, i);
            rdc(b | `REG_LEVEL, 32'h10000000);
            for (i = 0; i < 1024; i++) eng.pop(c, 1'b0);
            repeat (2) @(negedge clk);
            chk(eng.gotQ.size(), 1024);
            chk(eng.gotQ[1023], 1023);
            eng.gotQ.delete();
            // receive frame, last word of 1 to 4 bytes, ended with its last push
            for (i = 0; i < nr; i++) r[i] = $random(seed);
            for (i = 0; i < nr - 1; i++) eng.push(c, r[i], 3'h4, 1'b0);
            repeat (2) @(negedge clk);
            rdc(b | `REG_FRAMES, 32'h0);
            eng.push(c, r[nr-1], lb[2:0], 1'b1);
            repeat (3) @(negedge clk);
            rdc(b | `REG_FRAMES, 32'h1);
            rdc(b | `REG_LEVEL, s);
            chk({31'h0, rxEv[c]}, 32'h1);
            rdc(b | `REG_LEN, s);
            for (i = 0; i < nr; i++) rdc(b | `REG_DATA, r[i]);
            rdc(b | `REG_DATA, 32'h0);
            rdc(b | `REG_LEVEL, 32'h0);
        end
        // frozen block ignores a threshold write
        @(negedge clk);
        ce = 1'b0;
        wr(8'h80 | `REG_TRIG, ~v);
        ce = 1'b1;
        rdc(8'h80 | `REG_TRIG, trigv(v));
        complete_run();
    end
endmodule // testbench
bind dual_channel_frame_fifo_regs frame_fifo_asserts chk_i (.clk(clk), .srst(srst),
    .ce(ce), .hostRdEn(hostRdEn), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
    .txWordPop(txWordPop), .txWord(txWord), .txWordValid(txWordValid),
    .txLenPop(txLenPop), .txLen(txLen), .txLenValid(txLenValid),
    .transmitThresholdEvent(transmitThresholdEvent));
